// *** core/capture_event_square_timer.sv ***
// 16-bit capture / event counter / square-wave timer with an APB register slave
//
// Overview of operation
// - Free-run: selected edge on input 0 copies count to cc1, raises capture irq
// - Free-run: opposite edge on input 0 copies count into cc0
// - Capture inputs sampled on count clock; level must be seen twice
// - Restart mode: valid input 0 edge captures into cc1, then clears count
// - Overflow flag stays set until software writes one to clear it
// - Event mode: count increments once per valid input 0 edge
// - Event mode: count equal to cc0 clears count and raises match irq
// - Input 0 edge choice: rising, falling or both, via edge select field
// - Event mode: input 0 sampled every clock, level must be seen twice
// - Event mode: overflow only possible when cc0 holds the maximum
// - Output enable and toggle bits set: pin inverts on every cc0 match
// - Square mode: cc0 compares, match clears and restarts the count
// - Input 1 selected edge copies count into cc0, raises match irq
`timescale 1ns/1ps
`include "cest_defs.svh"
module capture_event_square_timer import cest_pkg::*; #(
  parameter int COUNT_W = 16
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic capture_input_0_in,
  input wire logic capture_input_1_in,
  output logic timer_output_pin_out,
  output logic irq_out
);
  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  generate
    if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_width
      $error("COUNT_W must lie between 2 and 32");
    end
  endgenerate

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    case (sel)
      `EDGE_FALL: edge_hit = f;
      `EDGE_RISE: edge_hit = r;
      `EDGE_BOTH: edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic edge_opp(input logic [1:0] sel, input logic r, input logic f);
    case (sel)
      `EDGE_FALL: edge_opp = r;
      `EDGE_RISE: edge_opp = f;
      default: edge_opp = 1'b0;
    endcase
  endfunction

  timer_mode_t mode_r;
  capctl_t capctl_r;
  prescale_t psc_r;
  outctl_t outctl_r;
  irq_bits_t status_r;
  irq_bits_t mask_r;
  irq_bits_t status_set;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] cc0_r;
  logic [COUNT_W-1:0] cc1_r;
  logic [`DIV_W-1:0] div_r;
  logic [1:0] smp_r;
  logic [1:0] lvl_r;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] pins;
  logic div_tick;
  logic samp_en;
  logic run;
  logic ext_clk;
  logic meas;
  logic tick;
  logic in0_hit;
  logic cap1_ev;
  logic cap0_opp_ev;
  logic cap0_in1_ev;
  logic restart_ev;
  logic match_ev;
  logic ovf_ev;
  logic tout_r;
  logic acc;
  logic wr;
  logic [31:0] rd_val;
  logic rd_err;

  // ----------------------------------------
  // Prescaler and input noise filter
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      div_r <= '0;
    end else if (clk_en_in) begin
      div_r <= div_r + `DIV_W'(1);
    end
  end

  always_comb begin
    case (psc_r.clk_sel)
      `CLK_DIV4: div_tick = (div_r & `DIV4_MASK) == `DIV4_MASK;
      `CLK_DIV256: div_tick = (div_r & `DIV256_MASK) == `DIV256_MASK;
      default: div_tick = 1'b1;
    endcase
  end

  // Event counting samples at the full clock; capture samples at the count clock
  assign ext_clk = psc_r.clk_sel == `CLK_EXT;
  assign samp_en = clk_en_in & (ext_clk | div_tick);
  assign pins = {capture_input_1_in, capture_input_0_in};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_filt
      // An edge counts only when two successive samples agree on the new level
      assign rise[i] = samp_en & (pins[i] == smp_r[i]) & pins[i] & ~lvl_r[i];
      assign fall[i] = samp_en & (pins[i] == smp_r[i]) & ~pins[i] & lvl_r[i];
      always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
          smp_r[i] <= 1'b0;
          lvl_r[i] <= 1'b0;
        end else if (samp_en) begin
          smp_r[i] <= pins[i];
          if (pins[i] == smp_r[i]) begin
            lvl_r[i] <= pins[i];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  assign run = clk_en_in && mode_r != MODE_STOP;
  assign in0_hit = edge_hit(psc_r.input0_edge_sel, rise[0], fall[0]);
  assign tick = run && (ext_clk ? in0_hit : div_tick);
  assign meas = run && !ext_clk && (mode_r == MODE_FREE || mode_r == MODE_RESTART);
  assign cap1_ev = meas && in0_hit;
  assign restart_ev = cap1_ev && mode_r == MODE_RESTART;
  assign cap0_opp_ev = meas && capctl_r.cc0_capture && !capctl_r.cc0_src_in1 &&
                       edge_opp(psc_r.input0_edge_sel, rise[0], fall[0]);
  assign cap0_in1_ev = meas && capctl_r.cc0_capture && capctl_r.cc0_src_in1 &&
                       edge_hit(psc_r.input1_edge_sel, rise[1], fall[1]);
  assign match_ev = tick && mode_r == MODE_CLEAR_MATCH && !capctl_r.cc0_capture &&
                    count_r == cc0_r;
  // A count left above a lower cc0 after a mode switch wraps silently in clear-on-match mode
  assign ovf_ev = tick && !restart_ev && count_r == {COUNT_W{1'b1}} &&
                  (mode_r != MODE_CLEAR_MATCH || cc0_r == {COUNT_W{1'b1}});

  // ----------------------------------------
  // Counter and capture registers
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
    end else if (clk_en_in) begin
      if (mode_r == MODE_STOP) begin
        count_r <= '0;
      end else if (restart_ev || match_ev) begin
        count_r <= '0;
      end else if (tick) begin
        count_r <= count_r + COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cc1_r <= '0;
    end else if (cap1_ev) begin
      cc1_r <= count_r;
    end
  end

  // Hardware capture wins over a software write in the same cycle
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cc0_r <= '0;
    end else if (cap0_opp_ev || cap0_in1_ev) begin
      cc0_r <= count_r;
    end else if (clk_en_in && wr && paddr_in == `OFS_CC0 && !capctl_r.cc0_capture) begin
      cc0_r <= pwdata_in[COUNT_W-1:0];
    end
  end

  // ----------------------------------------
  // Square-wave output
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tout_r <= 1'b0;
    end else if (clk_en_in) begin
      if (!outctl_r.output_enable_bit) begin
        tout_r <= 1'b0;
      end else if (outctl_r.toggle_on_match_bit && match_ev) begin
        tout_r <= ~tout_r;
      end
    end
  end
  assign timer_output_pin_out = tout_r;

  // ----------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------
  always_comb begin
    status_set = '0;
    status_set.match_irq_0 = match_ev | cap0_in1_ev;
    status_set.capture_irq_1 = cap1_ev;
    status_set.overflow_flag = ovf_ev;
  end

  // A set arriving with the write-one clear is kept
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      status_r <= '0;
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      if (wr && paddr_in == `OFS_STATUS) begin
        status_r <= (status_r & ~irq_bits_t'(pwdata_in[2:0])) | status_set;
      end else begin
        status_r <= status_r | status_set;
      end
      irq_out <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------
  // APB slave: no wait state, answer in the first access cycle
  // ----------------------------------------
  assign acc = psel_in && penable_in && pready_out;
  assign wr = acc && pwrite_in;

  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    case (paddr_in)
      `OFS_MODE: rd_val[1:0] = mode_r;
      `OFS_CAPCTL: rd_val[1:0] = capctl_r;
      `OFS_PRESCALE: rd_val[7:0] = psc_r;
      `OFS_OUTCTL: rd_val[1:0] = outctl_r;
      `OFS_COUNT: rd_val[COUNT_W-1:0] = count_r;
      `OFS_CC0: rd_val[COUNT_W-1:0] = cc0_r;
      `OFS_CC1: rd_val[COUNT_W-1:0] = cc1_r;
      `OFS_STATUS: rd_val[2:0] = status_r;
      `OFS_MASK: rd_val[2:0] = mask_r;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
    end else if (clk_en_in) begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && rd_err;
      prdata_out <= (psel_in && !penable_in && !pwrite_in) ? rd_val : '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      mode_r <= MODE_STOP;
      capctl_r <= '0;
      psc_r <= '0;
      outctl_r <= '0;
      mask_r <= '0;
    end else if (clk_en_in && wr) begin
      case (paddr_in)
        `OFS_MODE: mode_r <= timer_mode_t'(pwdata_in[1:0]);
        `OFS_CAPCTL: capctl_r <= capctl_t'(pwdata_in[1:0]);
        `OFS_PRESCALE: psc_r <= prescale_t'(pwdata_in[7:0]);
        `OFS_OUTCTL: outctl_r <= outctl_t'(pwdata_in[1:0]);
        `OFS_MASK: mask_r <= irq_bits_t'(pwdata_in[2:0]);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_cap1_load: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cap1_ev |=> cc1_r == $past(count_r) && status_r.capture_irq_1)
    else $error("cc1 capture or its flag missing");
  a_cap0_opposite: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cap0_opp_ev |=> cc0_r == $past(count_r))
    else $error("cc0 not loaded on opposite edge");
  a_filter_twice: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (lvl_r[0] != $past(lvl_r[0])) |-> $past(samp_en) && $past(smp_r[0]) == lvl_r[0])
    else $error("input level accepted after one sample");
  a_filter_fast: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (ext_clk && clk_en_in && capture_input_0_in != lvl_r[0]) ##1
    (clk_en_in && capture_input_0_in == $past(capture_input_0_in) && ext_clk) |=> lvl_r[0] == $past(capture_input_0_in))
    else $error("event input not accepted after two samples");
  a_restart_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    restart_ev |=> count_r == '0 && cc1_r == $past(count_r))
    else $error("restart capture did not clear count");
  a_ovf_sticky: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    status_r.overflow_flag && !(wr && paddr_in == `OFS_STATUS && pwdata_in[2]) |=> status_r.overflow_flag)
    else $error("overflow flag dropped without software clear");
  a_event_inc: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    tick && ext_clk && !match_ev |=> count_r == COUNT_W'($past(count_r) + COUNT_W'(1)))
    else $error("event edge did not increment count");
  a_match_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    match_ev |=> count_r == '0 && status_r.match_irq_0)
    else $error("match did not clear count or flag irq");
  a_ovf_only_max: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(status_r.overflow_flag) && $past(mode_r) == MODE_CLEAR_MATCH |-> $past(cc0_r) == {COUNT_W{1'b1}})
    else $error("overflow with cc0 below maximum");
  a_toggle_match: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    match_ev && outctl_r.output_enable_bit && outctl_r.toggle_on_match_bit |=> tout_r != $past(tout_r))
    else $error("output did not invert on match");
  a_in1_capture: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cap0_in1_ev |=> cc0_r == $past(count_r) && status_r.match_irq_0)
    else $error("input 1 capture into cc0 missing");
endmodule // capture_event_square_timer

// *** core/cest_defs.svh ***
// Register map, field codes and timing constants of the capture/event/square timer
`ifndef CEST_DEFS_SVH
`define CEST_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MODE 8'h00
`define OFS_CAPCTL 8'h04
`define OFS_PRESCALE 8'h08
`define OFS_OUTCTL 8'h0C
`define OFS_COUNT 8'h10
`define OFS_CC0 8'h14
`define OFS_CC1 8'h18
`define OFS_STATUS 8'h1C
`define OFS_MASK 8'h20
// ----------------------------------------
// Edge select codes
// ----------------------------------------
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h3
// ----------------------------------------
// Count clock select codes and divider masks
// ----------------------------------------
`define CLK_DIV1 2'h0
`define CLK_DIV4 2'h1
`define CLK_DIV256 2'h2
`define CLK_EXT 2'h3
`define DIV4_MASK 8'h03
`define DIV256_MASK 8'hFF
`define DIV_W 8
`endif

// *** core/cest_pkg.sv ***
// Types shared by the capture/event/square timer
package cest_pkg;
  // Counter operating mode
  typedef enum logic [1:0] {MODE_STOP, MODE_FREE, MODE_RESTART, MODE_CLEAR_MATCH} timer_mode_t;
  // Prescaler register layout
  typedef struct packed {
    logic [1:0] input1_edge_sel;
    logic [1:0] input0_edge_sel;
    logic [1:0] unused;
    logic [1:0] clk_sel;
  } prescale_t;
  // Capture control register layout
  typedef struct packed {
    logic cc0_src_in1;
    logic cc0_capture;
  } capctl_t;
  // Output control register layout
  typedef struct packed {
    logic toggle_on_match_bit;
    logic output_enable_bit;
  } outctl_t;
  // Sticky event bits, shared by status and mask
  typedef struct packed {
    logic overflow_flag;
    logic capture_irq_1;
    logic match_irq_0;
  } irq_bits_t;
endpackage

// *** tb/pulse_source.sv ***
// Partner model: an external pulse source driving one capture input
`timescale 1ns/1ps
module pulse_source (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic [7:0] width_in,
  output logic line_out
);
  logic [7:0] left_r;
  // Holds the high level for width_in cycles; a width of 1 is a deliberate glitch
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      line_out <= 1'b0;
      left_r <= 8'h00;
    end else if (go_in && left_r == 8'h00) begin
      line_out <= 1'b1;
      left_r <= width_in;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
      if (left_r == 8'h01) begin
        line_out <= 1'b0;
      end
    end
  end
endmodule // pulse_source

// *** tb/tb_top.sv ***
// Self-checking testbench of the capture/event/square timer
`timescale 1ns/1ps
`include "cest_defs.svh"
module tb_top;
  logic clock_in, rst_n_in, psel, penable, pwrite, pready, pslverr, in0, in1, pin, irq, go0, go1, err, en;
  logic [7:0] paddr, w;
  logic [31:0] pwdata, prdata, q, c0, c1;
  int n_errors, checks, seed, n, t;
  logic [7:0] codes [3] = '{8'h13, 8'h03, 8'h33};
  int mult [3] = '{1, 1, 2};
  capture_event_square_timer u_capture_event_square_timer (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .clk_en_in(en), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .capture_input_0_in(in0), .capture_input_1_in(in1), .timer_output_pin_out(pin), .irq_out(irq));
  pulse_source u_pulse_source0 (.clock_in(clock_in), .rst_n_in(rst_n_in), .go_in(go0), .width_in(w),
    .line_out(in0));
  pulse_source u_pulse_source1 (.clock_in(clock_in), .rst_n_in(rst_n_in), .go_in(go1), .width_in(w),
    .line_out(in1));
  // ----------------------------------------
  // Bus, pulse and compare helpers
  // ----------------------------------------
  // Master never assumes latency; only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic pulse(input logic k, input logic [7:0] width);
    @(posedge clock_in);
    go0 <= !k;
    go1 <= k;
    w <= width;
    @(posedge clock_in);
    go0 <= 1'b0;
    go1 <= 1'b0;
    repeat (width + 6) @(posedge clock_in);
  endtask
  // Count after p pulses: wraps from the compare value back to zero
  function automatic logic [31:0] exp_count(input int p, input int m, input int cmp);
    return (p * m) % (cmp + 1);
  endfunction
  task automatic final_report;
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    #(25ns * 90000);
    n_errors++;
    final_report();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n_in, psel, penable, pwrite, go0, go1} = '0;
    {paddr, w, pwdata} = '0;
    en = 1'b1;
    n_errors = 0;
    checks = 0;
    seed = 54;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rc(8'(a), 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `OFS_COUNT, 32'h5);
    rc(`OFS_COUNT, 32'h0);
    // Event counting, every edge code; software keeps cc0 nonzero
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `OFS_MODE, 32'h0);
      apb(1'b1, `OFS_CAPCTL, 32'h0);
      apb(1'b1, `OFS_PRESCALE, {24'h0, codes[i]});
      n = 3 + {$random(seed)} % 4;
      apb(1'b1, `OFS_CC0, n);
      apb(1'b1, `OFS_STATUS, 32'h7);
      apb(1'b1, `OFS_MODE, 32'h3);
      pulse(1'b0, 8'h01);
      rc(`OFS_COUNT, 32'h0);
      repeat (n) pulse(1'b0, 8'(3 + {$random(seed)} % 5));
      rc(`OFS_COUNT, exp_count(n, mult[i], n));
      rc(`OFS_STATUS, 32'(mult[i] == 2));
      pulse(1'b0, 8'h04);
      rc(`OFS_COUNT, exp_count(n + 1, mult[i], n));
      rc(`OFS_STATUS, 32'h1);
      apb(1'b1, `OFS_MASK, 32'h1);
      repeat (3) @(posedge clock_in);
      chk(irq, 1'b1);
      apb(1'b1, `OFS_STATUS, 32'h1);
      repeat (3) @(posedge clock_in);
      chk(irq, 1'b0);
      apb(1'b1, `OFS_MASK, 32'h0);
    end
    // Square wave; period only changed while stopped
    apb(1'b1, `OFS_MODE, 32'h0);
    apb(1'b1, `OFS_PRESCALE, 32'h0);
    apb(1'b1, `OFS_CAPCTL, 32'h0);
    apb(1'b1, `OFS_OUTCTL, 32'h3);
    n = 2 + {$random(seed)} % 6;
    apb(1'b1, `OFS_CC0, n);
    apb(1'b1, `OFS_MODE, 32'h3);
    for (int r = 0; r < 2; r++) begin
      c0[0] = pin;
      t = 0;
      while (pin === c0[0] && t < 100) begin
        @(posedge clock_in);
        t++;
      end
    end
    chk(t, n + 1);
    // Free-run two-register capture, then input 1 capture
    apb(1'b1, `OFS_MODE, 32'h0);
    apb(1'b1, `OFS_OUTCTL, 32'h0);
    apb(1'b1, `OFS_CAPCTL, 32'h1);
    apb(1'b1, `OFS_PRESCALE, 32'h10);
    apb(1'b1, `OFS_STATUS, 32'h7);
    apb(1'b1, `OFS_MODE, 32'h1);
    t = 3 + {$random(seed)} % 8;
    pulse(1'b0, 8'(t));
    apb(1'b0, `OFS_CC1, 32'h0);
    c1 = q;
    apb(1'b0, `OFS_CC0, 32'h0);
    chk(q - c1, t);
    rc(`OFS_STATUS, 32'h2);
    apb(1'b1, `OFS_MODE, 32'h0);
    apb(1'b1, `OFS_CAPCTL, 32'h3);
    apb(1'b1, `OFS_PRESCALE, 32'h50);
    apb(1'b1, `OFS_STATUS, 32'h7);
    apb(1'b1, `OFS_MODE, 32'h1);
    pulse(1'b1, 8'h04);
    rc(`OFS_STATUS, 32'h1);
    // Restart measurement
    apb(1'b1, `OFS_MODE, 32'h0);
    apb(1'b1, `OFS_CAPCTL, 32'h0);
    apb(1'b1, `OFS_PRESCALE, 32'h10);
    apb(1'b1, `OFS_MODE, 32'h2);
    repeat (200) @(posedge clock_in);
    pulse(1'b0, 8'h04);
    apb(1'b0, `OFS_COUNT, 32'h0);
    c0 = q;
    apb(1'b0, `OFS_CC1, 32'h0);
    chk(c0 < 64 && q >= 200, 1'b1);
    // Enable low freezes the count; only three enabled edges lie between the two sampled reads
    apb(1'b0, `OFS_COUNT, 32'h0);
    c1 = q;
    en <= 1'b0;
    repeat (50) @(posedge clock_in);
    en <= 1'b1;
    apb(1'b0, `OFS_COUNT, 32'h0);
    chk(q - c1, 32'h3);
    // Free-run wrap sets a sticky overflow
    apb(1'b1, `OFS_MODE, 32'h0);
    apb(1'b1, `OFS_STATUS, 32'h7);
    apb(1'b1, `OFS_MODE, 32'h1);
    repeat (65540) @(posedge clock_in);
    rc(`OFS_STATUS, 32'h4);
    repeat (20) @(posedge clock_in);
    rc(`OFS_STATUS, 32'h4);
    apb(1'b1, `OFS_STATUS, 32'h4);
    rc(`OFS_STATUS, 32'h0);
    final_report();
  end
endmodule // tb_top
